// [eac_top.sv]
// eeprom access control: apb register file, arm window, byte array, stalls
// assumes an apb master on clk_i; cpu_stall_o goes to the processor core
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - write starts only with arm set beforehand
// - arm lapses four cycles after being set
// - hardware clears write strobe when programming ends
// - write strobe stalls processor two cycles
// - read strobe loads addressed byte immediately
// - each read stalls processor four cycles, two when a write starts with it
// - busy write ignores reads and locks address
// - write lasts 8448 cycles of 1 MHz
module eac_top
  import eac_pkg::*;
#(
  parameter int WR_CYCLES = RC_WR_CYCLES
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic [31:0]      prdata_o,
  // core side
  input  wire logic        selfprog_enable_bit_i,
  output logic             cpu_stall_o,
  output logic             irq_o
);

  function automatic logic is_mapped(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    if (a == OFF_CTRL) begin
      hit = 1'b1;
    end else if (a == OFF_ADDR) begin
      hit = 1'b1;
    end else if (a == OFF_DATA) begin
      hit = 1'b1;
    end else if (a == OFF_STAT) begin
      hit = 1'b1;
    end else if (a == OFF_MASK) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  // register state
  logic [ADDR_W-1:0]  nvm_address_reg;
  logic [DATA_W-1:0]  nvm_data_reg;
  logic [STALL_W-1:0] arm_cnt;
  logic [ADDR_W-1:0]  wr_addr;
  logic [DATA_W-1:0]  wr_data;
  logic [ST_W-1:0]    stat;
  logic [ST_W-1:0]    mask;
  logic [ADDR_W-1:0]  next_nvm_address_reg;
  logic [DATA_W-1:0]  next_nvm_data_reg;
  logic [STALL_W-1:0] next_arm_cnt;
  logic [ADDR_W-1:0]  next_wr_addr;
  logic [DATA_W-1:0]  next_wr_data;
  logic [ST_W-1:0]    next_stat;
  logic [ST_W-1:0]    next_mask;

  logic [DATA_W-1:0]  mem [DEPTH];
  logic [DATA_W-1:0]  rd_byte;

  // bus decode
  logic               access;
  logic               wr_acc;
  logic               rd_acc;
  logic               ctrl_wr;
  logic               arm_act;
  logic               wr_busy;
  logic               wr_done;
  logic               wr_start;
  logic               wr_fail;
  logic               rd_start;
  logic               stall_load;
  logic [STALL_W-1:0] stall_len;
  logic [ST_W-1:0]    stat_set;
  logic [ST_W-1:0]    stat_clr;

  // a stall holds off the next bus access, which is how the core waits
  assign pready_o  = !cpu_stall_o;
  assign access    = psel_i && penable_i && pready_o;
  assign wr_acc    = access && pwrite_i && pstrb_i[0];
  assign rd_acc    = access && !pwrite_i;
  assign pslverr_o = psel_i && penable_i && !is_mapped(paddr_i);
  assign ctrl_wr   = wr_acc && (paddr_i == OFF_CTRL);
  assign arm_act   = (arm_cnt != '0);
  assign rd_byte   = mem[nvm_address_reg];

  // strobe only counts when the arm was already open before this write
  assign wr_start = ctrl_wr && pwdata_i[CTRL_WR] && arm_act && !wr_busy;
  assign wr_fail  = ctrl_wr && pwdata_i[CTRL_WR] && !arm_act && !wr_busy;
  assign rd_start = ctrl_wr && pwdata_i[CTRL_RD] && !wr_busy;

  assign stall_load = wr_start || rd_start;
  assign stall_len  = wr_start ? STALL_WR : STALL_RD;

  assign stat_set = {wr_fail, wr_done};
  assign stat_clr = (rd_acc && paddr_i == OFF_STAT) ? {ST_W{1'b1}} : '0;
  assign irq_o    = |(stat & mask);

  always_comb begin
    next_nvm_address_reg = nvm_address_reg;
    next_nvm_data_reg    = nvm_data_reg;
    next_arm_cnt         = arm_cnt;
    next_wr_addr         = wr_addr;
    next_wr_data         = wr_data;
    next_mask            = mask;
    // a new event wins over the read clear
    next_stat            = (stat & ~stat_clr) | stat_set;
    if (arm_act) begin
      next_arm_cnt = arm_cnt - 3'h1;
    end
    if (ctrl_wr) begin
      if (pwdata_i[CTRL_WR]) begin
        next_arm_cnt = '0;
      end else if (pwdata_i[CTRL_ARM]) begin
        next_arm_cnt = ARM_WINDOW;
      end
    end
    if (wr_start) begin
      next_wr_addr = nvm_address_reg;
      next_wr_data = nvm_data_reg;
    end
    if (wr_acc && paddr_i == OFF_ADDR && !wr_busy) begin
      next_nvm_address_reg = pwdata_i[ADDR_W-1:0];
    end
    if (wr_acc && paddr_i == OFF_DATA) begin
      next_nvm_data_reg = pwdata_i[DATA_W-1:0];
    end
    if (rd_start) begin
      next_nvm_data_reg = rd_byte;
    end
    if (wr_acc && paddr_i == OFF_MASK) begin
      next_mask = pwdata_i[ST_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nvm_address_reg <= ADDR_RST;
      nvm_data_reg    <= DATA_RST;
      arm_cnt         <= '0;
      wr_addr         <= ADDR_RST;
      wr_data         <= DATA_RST;
      stat            <= STAT_RST;
      mask            <= MASK_RST;
    end else begin
      nvm_address_reg <= next_nvm_address_reg;
      nvm_data_reg    <= next_nvm_data_reg;
      arm_cnt         <= next_arm_cnt;
      wr_addr         <= next_wr_addr;
      wr_data         <= next_wr_data;
      stat            <= next_stat;
      mask            <= next_mask;
    end
  end

  // array has no reset, like the cells it stands for
  always_ff @(posedge clk_i) begin
    if (wr_done) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_comb begin
    prdata_o = 32'h0000_0000;
    if (paddr_i == OFF_CTRL) begin
      prdata_o[CTRL_WR]  = wr_busy;
      prdata_o[CTRL_ARM] = arm_act;
      prdata_o[CTRL_SPM] = selfprog_enable_bit_i;
    end else if (paddr_i == OFF_ADDR) begin
      prdata_o[ADDR_W-1:0] = nvm_address_reg;
    end else if (paddr_i == OFF_DATA) begin
      prdata_o[DATA_W-1:0] = nvm_data_reg;
    end else if (paddr_i == OFF_STAT) begin
      prdata_o[ST_W-1:0] = stat;
    end else if (paddr_i == OFF_MASK) begin
      prdata_o[ST_W-1:0] = mask;
    end
  end

  eac_rc_timer #(
    .DIV    (RC_DIV),
    .CYCLES (WR_CYCLES)
  ) u_timer (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .start_i  (wr_start),
    .busy_o   (wr_busy),
    .done_o   (wr_done)
  );

  eac_stall u_stall (
    .clk_i    (clk_i),
    .arst_n_i (arst_n_i),
    .load_i   (stall_load),
    .len_i    (stall_len),
    .stall_o  (cpu_stall_o)
  );

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_no_arm_write: assert property (
    ctrl_wr && pwdata_i[CTRL_WR] && !arm_act && !wr_busy |=> !wr_busy && stat[ST_FAIL])
    else $error("write started without arm");
  a_arm_timeout: assert property (
    ctrl_wr && pwdata_i[CTRL_ARM] && !pwdata_i[CTRL_WR] ##1 !ctrl_wr [*4] |=> !arm_act)
    else $error("arm did not lapse after four cycles");
  a_strobe_clears: assert property (
    wr_done |=> !wr_busy)
    else $error("write strobe still set after programming");
  a_write_stall: assert property (
    wr_start |=> cpu_stall_o [*2] ##1 !cpu_stall_o)
    else $error("write stall not two cycles");
  a_read_data: assert property (
    rd_start |=> nvm_data_reg == $past(rd_byte))
    else $error("read byte not loaded");
  a_read_stall: assert property (
    rd_start |=> cpu_stall_o [*4] ##1 !cpu_stall_o)
    else $error("read stall not four cycles");
  a_busy_addr_hold: assert property (
    wr_busy |=> $stable(nvm_address_reg))
    else $error("address changed during write");
  a_busy_no_read: assert property (
    wr_busy && ctrl_wr && pwdata_i[CTRL_RD] |=> $stable(nvm_data_reg))
    else $error("read done during write");
  a_addr_load: assert property (
    wr_acc && paddr_i == OFF_ADDR && !wr_busy |=> nvm_address_reg == $past(pwdata_i[ADDR_W-1:0]))
    else $error("address not loaded");

  // cycles since the strobe; the programming time is far beyond a delay range
  localparam logic [31:0] WR_LAST = 32'(RC_DIV * WR_CYCLES - 1);
  logic [31:0] wr_age;
  logic [31:0] next_wr_age;

  always_comb begin
    next_wr_age = wr_age;
    if (wr_start) begin
      next_wr_age = '0;
    end else if (wr_busy) begin
      next_wr_age = wr_age + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_age <= '0;
    end else begin
      wr_age <= next_wr_age;
    end
  end

  a_arm_open: assert property (
    ctrl_wr && pwdata_i[CTRL_ARM] && !pwdata_i[CTRL_WR] |=> arm_cnt == ARM_WINDOW)
    else $error("arm window not opened");
  a_strobe_closes: assert property (
    ctrl_wr && pwdata_i[CTRL_WR] |=> !arm_act)
    else $error("arm still open after a strobe");
  a_write_capture: assert property (
    wr_start |=> wr_busy && wr_addr == $past(nvm_address_reg) && wr_data == $past(nvm_data_reg))
    else $error("write address or data not captured");
  a_done_flag: assert property (
    wr_done |=> stat[ST_DONE])
    else $error("done flag not set");
  a_stat_clear: assert property (
    rd_acc && paddr_i == OFF_STAT && !wr_done && !wr_fail |=> stat == '0)
    else $error("status not cleared by read");
  a_write_lands: assert property (
    wr_done |=> mem[wr_addr] == wr_data)
    else $error("byte not stored at end of write");
  a_write_length: assert property (
    wr_done |-> wr_age == WR_LAST)
    else $error("write ended before its programming time");
  a_write_ends: assert property (
    wr_busy && wr_age == WR_LAST |-> wr_done)
    else $error("write ran past its programming time");
  a_read_bus_hold: assert property (
    rd_start |=> !pready_o [*4] ##1 pready_o)
    else $error("bus not held four cycles after read");

  c_write_started: cover property (wr_start);
  c_busy_refused: cover property (wr_busy && ctrl_wr && pwdata_i[CTRL_RD]);
  c_write_done: cover property (wr_done ##1 irq_o);
  c_arm_lapsed: cover property (wr_fail);
  c_read_done: cover property (rd_start);

endmodule
`default_nettype wire

// [eac_pkg.sv]
// eeprom access control: shared constants, register map and field layout
// assumes a 200 MHz system clock and a 1 MHz calibrated rc timebase
package eac_pkg;

  // geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int DEPTH  = 512;

  // apb register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_ADDR = 12'h004;
  localparam logic [11:0] OFF_DATA = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00c;
  localparam logic [11:0] OFF_MASK = 12'h010;

  // control register bit positions
  localparam int CTRL_RD  = 0;
  localparam int CTRL_WR  = 1;
  localparam int CTRL_ARM = 2;
  localparam int CTRL_SPM = 3;

  // status / mask bit positions
  localparam int ST_DONE = 0;
  localparam int ST_FAIL = 1;
  localparam int ST_W    = 2;

  // reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ST_W-1:0]   STAT_RST = 2'h0;
  localparam logic [ST_W-1:0]   MASK_RST = 2'h0;

  // timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int RC_PERIOD_NS  = 1000;
  localparam int RC_DIV        = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_WR_CYCLES  = 8448;
  localparam int STALL_W       = 3;
  localparam logic [STALL_W-1:0] ARM_WINDOW = 3'h4;
  localparam logic [STALL_W-1:0] STALL_WR   = 3'h2;
  localparam logic [STALL_W-1:0] STALL_RD   = 3'h4;

endpackage

// [eac_stall.sv]
// eeprom access control: processor stall counter
// assumes load_i is a one-cycle pulse; a load wins over the running count
`timescale 1ns/10ps
`default_nettype none
module eac_stall
  import eac_pkg::*;
(
  // clock and reset
  input  wire logic               clk_i,
  input  wire logic               arst_n_i,
  // request
  input  wire logic               load_i,
  input  wire logic [STALL_W-1:0] len_i,
  // stall
  output logic                    stall_o
);

  logic [STALL_W-1:0] cnt;
  logic [STALL_W-1:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (load_i) begin
      next_cnt = len_i;
    end else if (cnt != '0) begin
      next_cnt = cnt - 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign stall_o = (cnt != '0);

endmodule
`default_nettype wire

// [eac_rc_timer.sv]
// eeprom access control: write programming timer on the rc timebase
// the rc tick is derived from the system clock, so no second domain exists
`timescale 1ns/10ps
`default_nettype none
module eac_rc_timer
  import eac_pkg::*;
#(
  parameter int DIV    = RC_DIV,
  parameter int CYCLES = RC_WR_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  // control
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  localparam int DW = $clog2(DIV + 1);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);
  localparam logic [CW-1:0] CYC_LAST = CW'(CYCLES - 1);

  logic          run;
  logic [DW-1:0] div_cnt;
  logic [CW-1:0] rc_cnt;
  logic          next_run;
  logic [DW-1:0] next_div_cnt;
  logic [CW-1:0] next_rc_cnt;

  assign done_o = run && (div_cnt == DIV_LAST) && (rc_cnt == CYC_LAST);
  assign busy_o = run;

  always_comb begin
    next_run     = run;
    next_div_cnt = div_cnt;
    next_rc_cnt  = rc_cnt;
    if (start_i) begin
      next_run     = 1'b1;
      next_div_cnt = '0;
      next_rc_cnt  = '0;
    end else if (run) begin
      if (div_cnt == DIV_LAST) begin
        next_div_cnt = '0;
        if (rc_cnt == CYC_LAST) begin
          next_run = 1'b0;
        end else begin
          next_rc_cnt = rc_cnt + CW'(1);
        end
      end else begin
        next_div_cnt = div_cnt + DW'(1);
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run     <= 1'b0;
      div_cnt <= '0;
      rc_cnt  <= '0;
    end else begin
      run     <= next_run;
      div_cnt <= next_div_cnt;
      rc_cnt  <= next_rc_cnt;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  a_timer_start: assert property (start_i |=> busy_o && div_cnt == '0 && rc_cnt == '0)
    else $error("write timer did not restart");
  a_timer_finish: assert property (done_o |=> !busy_o)
    else $error("timer busy after done");

endmodule
`default_nettype wire

// [eac_cpu_model.sv]
// processor-side model: apb master issuing register accesses
// assumes one clock; requests start after a rising edge and hold until taken
`timescale 1ns/10ps
`default_nettype none
module eac_cpu_model (
  // clock
  input  wire logic        clk_i,
  // apb master
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [11:0]      paddr_o,
  output logic [31:0]      pwdata_o,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 12'h000;
    pwdata_o = 32'h0;
  end

  // arm writes carry strobe 0, callers poll busy first, keep sequences atomic
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    // wait states end at the rising edge where pready is seen high
    do begin
      @(posedge clk_i);
    end while (pready_i !== 1'b1);
    q = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [eac_top_bench.sv]
// self-checking bench for the eeprom access control block
// assumes a short programming timer so a write fits in the run
`timescale 1ns/10ps
`default_nettype none
module eac_top_bench
  import eac_pkg::*;
;
  logic        clk_i;
  logic        arst_n_i = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, stall, irq;
  logic        spm = 1'b1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic        e;
  int          n_fail = 0;
  int          compares = 0;
  int          cyc = 0;
  int          s, i;

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) cyc <= cyc + 1;

  eac_cpu_model i_eac_cpu_model (.clk_i(clk_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pready_i(pready),
    .pslverr_i(pslverr), .prdata_i(prdata));

  eac_top #(.WR_CYCLES(4)) i_eac_top (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(4'hf), .pready_o(pready), .pslverr_o(pslverr),
    .prdata_o(prdata), .selfprog_enable_bit_i(spm), .cpu_stall_o(stall), .irq_o(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        er;
    i_eac_cpu_model.xfer(1'b1, a, d, r, er);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        er;
    i_eac_cpu_model.xfer(1'b0, a, 32'h0, r, er);
    chk(r, exp);
  endtask

  // stall high for n cycles after the taking edge, pready held low meanwhile
  task automatic stl(input int n);
    repeat (n) begin
      @(negedge clk_i);
      chk({30'h0, stall, pready}, 32'h2);
    end
    @(negedge clk_i);
    chk({30'h0, stall, pready}, 32'h1);
  endtask

  task automatic results;
    $display("comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    results();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(OFF_CTRL, 32'h8);
    rd(OFF_ADDR, 32'h0);
    rd(OFF_DATA, 32'h0);
    rd(OFF_STAT, 32'h0);
    rd(OFF_MASK, 32'h0);
    i_eac_cpu_model.xfer(1'b0, 12'h014, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1);
    spm <= 1'b0;
    rd(OFF_CTRL, 32'h0);
    $display("test reset done");
    wr(OFF_CTRL, 32'h2);
    chk({31'h0, irq}, 32'h0);
    rd(OFF_STAT, 32'h2);
    rd(OFF_STAT, 32'h0);
    wr(OFF_CTRL, 32'h4);
    repeat (2) @(posedge clk_i);
    wr(OFF_CTRL, 32'h2);
    rd(OFF_STAT, 32'h2);
    wr(OFF_CTRL, 32'h6);
    wr(OFF_CTRL, 32'h2);
    rd(OFF_STAT, 32'h2);
    $display("test refused done");
    wr(OFF_MASK, 32'h1);
    wr(OFF_DATA, 32'ha5);
    wr(OFF_ADDR, 32'h3ff);
    rd(OFF_ADDR, 32'h1ff);
    wr(OFF_CTRL, 32'h4);
    @(posedge clk_i);
    wr(OFF_CTRL, 32'h2);
    s = cyc;
    stl(2);
    rd(OFF_CTRL, 32'h2);
    wr(OFF_ADDR, 32'h055);
    rd(OFF_ADDR, 32'h1ff);
    wr(OFF_CTRL, 32'h1);
    rd(OFF_DATA, 32'ha5);
    for (i = 0; i < 400; i++) begin
      i_eac_cpu_model.xfer(1'b0, OFF_CTRL, 32'h0, q, e);
      if (q[1] === 1'b0) break;
    end
    chk({31'h0, cyc - s >= 800 && cyc - s <= 806}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(OFF_STAT, 32'h1);
    // the clear lands at the taking edge, so look once it has settled
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h0);
    $display("test write done");
    wr(OFF_DATA, 32'h0);
    wr(OFF_CTRL, 32'h1);
    stl(4);
    rd(OFF_DATA, 32'ha5);
    $display("test read done");
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(OFF_DATA, 32'h0);
    rd(OFF_MASK, 32'h0);
    rd(OFF_STAT, 32'h0);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
